/* cps_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz sequencer clock
// Notes:   included by both ends and by the testbench
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// Clock rate
`define CPS_CLK_HZ          10000000
// Bias regulator start delay, nominal (least 100 ms)
`define CPS_BIAS_DLY_MS     220
// Poor source retry period
`define CPS_RETRY_MS        2000
// Settle time of the loaded-voltage check
`define CPS_LOAD_SETTLE_US  100

// Device register offsets
`define CPS_OFS_SRC_CTL     4'h0
`define CPS_OFS_WDOG        4'h5
`define CPS_OFS_MISC        4'h7
`define CPS_OFS_STATUS      4'h8

// Field positions
`define CPS_HIZ_BIT         7
`define CPS_CURRENT_LIMIT_PIN_LSB        0
`define CPS_WDOG_LSB        4
`define CPS_FDET_BIT        7
`define CPS_BSWDIS_BIT      5
`define CPS_SRC_LSB         6
`define CPS_PG_BIT          2

// Reset values
`define CPS_CURRENT_LIMIT_PIN_RST        3'h0
`define CPS_WDOG_RST        2'h1

// Input limit codes
`define CPS_CURRENT_LIMIT_PIN_100MA      3'h0
`define CPS_CURRENT_LIMIT_PIN_500MA      3'h2
`define CPS_CURRENT_LIMIT_PIN_3A         3'h7

// Source type codes
`define CPS_SRC_NONE        2'h0
`define CPS_SRC_USB         2'h1
`define CPS_SRC_ADAPTER     2'h2

// Host controller user registers
`define CPS_HOFS_CMD        2'h0
`define CPS_HOFS_CTRL       2'h1
`define CPS_HOFS_STATUS     2'h2
`define CPS_HCMD_SHIP       0
`define CPS_HCMD_CLRHIZ     1
`define CPS_HCMD_FDET       2
`define CPS_HCMD_NOBAT      3

`endif

/* cps_pkg.sv */
// Purpose: shared types of the power-up sequencer and its host controller
// Assumes: cps_regs.svh holds the numbers
// Notes:   none
package cps_pkg;
	typedef enum logic [2:0] {
		CPS_D_IDLE, CPS_D_BIASDLY, CPS_D_QUAL, CPS_D_RETRY, CPS_D_DETECT, CPS_D_RUN
	} cps_dev_state_t;

	typedef enum logic [2:0] {
		CPS_H_WAKE_RD, CPS_H_WAKE_CAP, CPS_H_IDLE, CPS_H_HIZ_CAP, CPS_H_SHIP2
	} cps_host_state_t;

	typedef logic [7:0] cps_byte_t;
endpackage

/* cps_link_if.sv */
// Purpose: serial-bus register path, power-good and interrupt between host and charger
// Assumes: one clock shared by both ends
// Notes:   port_type is driven directly by a testbench variable
`timescale 1ns/1ns
interface cps_link_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       pg_n;
	logic       int_evt;
	logic       port_type;
	logic       boost_req;

	modport device (input addr, wdata, wr, rd, port_type, boost_req,
		output rdata, pg_n, int_evt);
	modport host (output addr, wdata, wr, rd, boost_req,
		input rdata, pg_n, int_evt);
endinterface // cps_link_if

/* cps_device.sv */
// Purpose: power-up and input-source sequencer of a single-cell charger
// Assumes: comparator inputs are digital levels, sampled here
// Notes:   long delays are parameters so simulation can shorten them
// What this block does
// [RULE_01] Supply rise readies bus, resets registers
// [RULE_02] Battery only: switch closed, bias off
// [RULE_03] Rail overload opens switch until input returns
// [RULE_04] Disable bit forces battery switch open
// [RULE_05] Host disables switch when no battery
// [RULE_06] Shipping: watchdog off and disable together
// [RULE_07] Adapter connect re-enables battery switch
// [RULE_08] Bias on after conditions plus delay
// [RULE_09] Unmet bias condition keeps high impedance
// [RULE_10] Check overvoltage and loaded input before converter
// [RULE_11] Qualified source sets power-good and interrupt
// [RULE_12] Failed loaded check retries every 2 s
// [RULE_13] Detect right after power-good
// [RULE_14] Port type and boost pins choose limit
// [RULE_15] Host may rewrite limit after detection
// [RULE_16] 100 mA port, good battery: enter high impedance
// [RULE_17] Host mode high impedance held until cleared
// [RULE_18] Host reads high impedance state first on wake
// [RULE_19] Default mode: clear on removal, redetect
// [RULE_20] Force-detection bit starts detection, self-clears
// [RULE_21] Then converter on; switch follows charge enable
// [RULE_22] Soft-start 100 mA below 2.2 V, then minimum
// [RULE_23] Comparator inputs synchronised to digital clock
`timescale 1ns/1ns
`include "cps_regs.svh"
module cps_device #(
	parameter int unsigned BIAS_DLY_CYC = `CPS_BIAS_DLY_MS * (`CPS_CLK_HZ / 1000),
	parameter int unsigned RETRY_CYC    = `CPS_RETRY_MS * (`CPS_CLK_HZ / 1000),
	parameter int unsigned SETTLE_CYC   = `CPS_LOAD_SETTLE_US * (`CPS_CLK_HZ / 1000000),
	parameter int unsigned NCMP         = 12
) (
	// Clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	// Link to host and PHY
	cps_link_if.device      link,
	// Comparator levels
	input  wire logic       vbus_uvlo_ok_i,
	input  wire logic       vbat_uvlo_ok_i,
	input  wire logic       bat_above_depl_i,
	input  wire logic       sys_overload_i,
	input  wire logic       vbus_above_sleep_i,
	input  wire logic       vbus_below_ovp_i,
	input  wire logic       vbus_loaded_ok_i,
	input  wire logic       bat_good_i,
	input  wire logic       sys_above_2v2_i,
	// Operating mode levels
	input  wire logic       boost_mode_i,
	input  wire logic       host_mode_i,
	input  wire logic       charge_en_i,
	// Current limit pin setting
	input  wire logic [2:0] current_limit_pin_pin_i,
	// Power stage controls
	output logic            bsw_on_o,
	output logic            bias_en_o,
	output logic            test_load_o,
	output logic            conv_en_o,
	output logic            hiz_o,
	output logic [2:0]      current_limit_pin_active_o
);
	import cps_pkg::*;

	logic [NCMP-1:0]  cmp_raw;
	logic [NCMP-1:0]  sync1_r;
	logic [NCMP-1:0]  sync2_r;
	cps_dev_state_t   state_r;
	logic [31:0]      cnt_r;
	logic             hiz_r;
	logic [2:0]       current_limit_pin_r;
	logic [1:0]       wdog_r;
	logic             fdet_r;
	logic             bswdis_r;
	logic [1:0]       src_r;
	logic             pg_r;
	logic             ovl_r;
	logic             vbus_q_r;

	assign cmp_raw = {sys_above_2v2_i, bat_good_i, vbus_loaded_ok_i, vbus_below_ovp_i,
		vbus_above_sleep_i, sys_overload_i, bat_above_depl_i, vbat_uvlo_ok_i,
		vbus_uvlo_ok_i, boost_mode_i, host_mode_i, charge_en_i};

	// [RULE_23] two-flop comparator sync
	genvar gi;
	generate
		for (gi = 0; gi < NCMP; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else if (ce_i) begin
					sync1_r[gi] <= cmp_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// Synchronised levels
	wire s_charge  = sync2_r[0];
	wire s_host    = sync2_r[1];
	wire s_boost   = sync2_r[2];
	wire s_vbus    = sync2_r[3];
	wire s_vbat    = sync2_r[4];
	wire s_depl    = sync2_r[5];
	wire s_ovl     = sync2_r[6];
	wire s_sleep   = sync2_r[7];
	wire s_ovp_ok  = sync2_r[8];
	wire s_loaded  = sync2_r[9];
	wire s_batgd   = sync2_r[10];
	wire s_sys2v2  = sync2_r[11];

	// Supply and bias conditions
	wire supply_ok = s_vbus | s_vbat;
	wire vbus_rise = s_vbus & ~vbus_q_r;
	wire vbus_fall = ~s_vbus & vbus_q_r;
	// [RULE_08] bias enable conditions
	wire bias_cond = s_vbus & (s_boost ? ~s_sleep : s_sleep) & ~hiz_r;
	wire cnt_bias  = (cnt_r == BIAS_DLY_CYC - 1);
	wire cnt_retry = (cnt_r == RETRY_CYC - 1);
	wire cnt_set   = (cnt_r == SETTLE_CYC - 1);
	// [RULE_10] qualification result
	wire qual_ok   = s_ovp_ok & s_loaded;

	// Register access decode
	wire wr_src  = link.wr & (link.addr == `CPS_OFS_SRC_CTL);
	wire wr_wdog = link.wr & (link.addr == `CPS_OFS_WDOG);
	wire wr_misc = link.wr & (link.addr == `CPS_OFS_MISC);
	wire in_det  = (state_r == CPS_D_DETECT);
	// [RULE_14] pin-based limit selection
	wire [2:0] det_current_limit_pin = ~link.port_type ? `CPS_CURRENT_LIMIT_PIN_3A :
		(link.boost_req ? `CPS_CURRENT_LIMIT_PIN_500MA : `CPS_CURRENT_LIMIT_PIN_100MA);
	wire [1:0] det_src  = link.port_type ? `CPS_SRC_USB : `CPS_SRC_ADAPTER;
	// [RULE_16] 100 mA port with good battery
	wire det_hiz = link.port_type & ~link.boost_req & s_batgd;
	// [RULE_22] lower of register and pin
	wire [2:0] current_limit_pin_min = (current_limit_pin_r < current_limit_pin_pin_i) ? current_limit_pin_r : current_limit_pin_pin_i;

	// Sequencer state and timer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= CPS_D_IDLE;
			cnt_r   <= 32'h0;
		end else if (ce_i) begin
			cnt_r <= cnt_r + 32'h1;
			unique case (state_r)
				CPS_D_IDLE: begin
					cnt_r <= 32'h0;
					if (bias_cond)
						state_r <= CPS_D_BIASDLY;
				end
				CPS_D_BIASDLY: begin
					if (cnt_bias) begin
						state_r <= CPS_D_QUAL;
						cnt_r   <= 32'h0;
					end
				end
				CPS_D_QUAL: begin
					if (cnt_set) begin
						cnt_r   <= 32'h0;
						// [RULE_12] retry on failed check
						state_r <= qual_ok ? CPS_D_DETECT : CPS_D_RETRY;
					end
				end
				CPS_D_RETRY: begin
					if (cnt_retry) begin
						state_r <= CPS_D_QUAL;
						cnt_r   <= 32'h0;
					end
				end
				CPS_D_DETECT: state_r <= CPS_D_RUN;
				CPS_D_RUN: begin
					// [RULE_20] forced redetection
					if (fdet_r)
						state_r <= CPS_D_DETECT;
				end
			endcase
			// [RULE_09] unmet condition drops to high impedance
			if (!bias_cond)
				state_r <= CPS_D_IDLE;
		end
	end

	// Control registers
	// [RULE_01] registers default while no supply is up
	always_ff @(posedge clk_i) begin
		if (srst_i || (ce_i && !supply_ok)) begin
			hiz_r    <= 1'b0;
			current_limit_pin_r   <= `CPS_CURRENT_LIMIT_PIN_RST;
			wdog_r   <= `CPS_WDOG_RST;
			fdet_r   <= 1'b0;
			bswdis_r <= 1'b0;
		end else if (ce_i) begin
			// [RULE_15] host may rewrite limit
			if (wr_src)
				current_limit_pin_r <= link.wdata[`CPS_CURRENT_LIMIT_PIN_LSB +: 3];
			if (wr_wdog)
				wdog_r <= link.wdata[`CPS_WDOG_LSB +: 2];
			// [RULE_17] only a host write clears in host mode
			if (wr_src)
				hiz_r <= link.wdata[`CPS_HIZ_BIT];
			// [RULE_19] default mode clears on removal
			else if (vbus_fall && !s_host)
				hiz_r <= 1'b0;
			if (in_det) begin
				current_limit_pin_r <= det_current_limit_pin;
				if (det_hiz)
					hiz_r <= 1'b1;
			end
			// [RULE_20] self-clear, a new set wins
			if (wr_misc && link.wdata[`CPS_FDET_BIT])
				fdet_r <= 1'b1;
			else if (in_det)
				fdet_r <= 1'b0;
			// [RULE_07] adapter connect re-enables switch
			if (wr_misc)
				bswdis_r <= link.wdata[`CPS_BSWDIS_BIT];
			else if (vbus_rise)
				bswdis_r <= 1'b0;
		end
	end

	// Status, overload latch and interrupt
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			src_r        <= `CPS_SRC_NONE;
			pg_r         <= 1'b0;
			ovl_r        <= 1'b0;
			vbus_q_r     <= 1'b0;
			link.int_evt <= 1'b0;
			link.pg_n    <= 1'b1;
		end else if (ce_i) begin
			vbus_q_r     <= s_vbus;
			link.int_evt <= 1'b0;
			// [RULE_11] power-good, pin and interrupt
			if (state_r == CPS_D_QUAL && cnt_set && qual_ok && !pg_r) begin
				pg_r         <= 1'b1;
				link.pg_n    <= 1'b0;
				link.int_evt <= 1'b1;
			end else if (!s_vbus) begin
				pg_r      <= 1'b0;
				link.pg_n <= 1'b1;
			end
			if (in_det)
				src_r <= det_src;
			else if (!s_vbus)
				src_r <= `CPS_SRC_NONE;
			// [RULE_03] latch overload until input returns
			if (s_vbus)
				ovl_r <= 1'b0;
			else if (s_ovl)
				ovl_r <= 1'b1;
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.rdata <= 8'h00;
		end else if (ce_i) begin
			link.rdata <= 8'h00;
			if (link.rd) begin
				unique case (link.addr)
					`CPS_OFS_SRC_CTL: link.rdata <= {hiz_r, 4'h0, current_limit_pin_r};
					`CPS_OFS_WDOG:    link.rdata <= {2'h0, wdog_r, 4'h0};
					`CPS_OFS_MISC:    link.rdata <= {fdet_r, 1'b0, bswdis_r, 5'h00};
					`CPS_OFS_STATUS:  link.rdata <= {src_r, 3'h0, pg_r, 2'h0};
					default:          link.rdata <= 8'h00;
				endcase
			end
		end
	end

	// Power stage outputs
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bsw_on_o      <= 1'b0;
			bias_en_o     <= 1'b0;
			test_load_o   <= 1'b0;
			conv_en_o     <= 1'b0;
			hiz_o         <= 1'b1;
			current_limit_pin_active_o <= `CPS_CURRENT_LIMIT_PIN_100MA;
		end else if (ce_i) begin
			// [RULE_02] bias only with input; battery alone feeds system
			// [RULE_08] regulator waits out the start delay
			bias_en_o   <= (state_r != CPS_D_IDLE) && (state_r != CPS_D_BIASDLY);
			hiz_o       <= (state_r == CPS_D_IDLE);
			test_load_o <= (state_r == CPS_D_QUAL);
			// [RULE_21] converter after limit is set
			conv_en_o   <= (state_r == CPS_D_RUN);
			// [RULE_04] disable bit overrides all
			if (bswdis_r || ovl_r)
				bsw_on_o <= 1'b0;
			else if (state_r == CPS_D_RUN)
				bsw_on_o <= s_charge;
			else
				bsw_on_o <= s_depl | s_vbus;
			// [RULE_22] soft-start limit
			current_limit_pin_active_o <= s_sys2v2 ? current_limit_pin_min : `CPS_CURRENT_LIMIT_PIN_100MA;
		end
	end
endmodule // cps_device

/* cps_host.sv */
// Purpose: host-side controller driving the charger registers
// Assumes: user port strobes are one cycle, never both at once
// Notes:   commands arriving while busy are dropped; busy shows in status
`timescale 1ns/1ns
`include "cps_regs.svh"
module cps_host (
	// Clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	// User register port
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	// Link to charger
	cps_link_if.host        link
);
	import cps_pkg::*;

	cps_host_state_t state_r;
	logic            wake_hiz_r;
	logic            nobat_r;
	logic            int_seen_r;
	logic            clr_pend_r;

	wire wr_cmd  = wr_i & (addr_i == `CPS_HOFS_CMD) & (state_r == CPS_H_IDLE);
	wire wr_ctrl = wr_i & (addr_i == `CPS_HOFS_CTRL);
	wire busy    = (state_r != CPS_H_IDLE);
	wire [7:0] misc_wd = {1'b0, 1'b0, nobat_r, 5'h00};

	// Command sequencer, one link access per cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r    <= CPS_H_WAKE_RD;
			link.addr  <= 4'h0;
			link.wdata <= 8'h00;
			link.wr    <= 1'b0;
			link.rd    <= 1'b0;
			wake_hiz_r <= 1'b0;
			nobat_r    <= 1'b0;
			clr_pend_r <= 1'b0;
		end else if (ce_i) begin
			link.wr <= 1'b0;
			link.rd <= 1'b0;
			unique case (state_r)
				// [RULE_18] first access reads high impedance state
				CPS_H_WAKE_RD: begin
					link.addr <= `CPS_OFS_SRC_CTL;
					link.rd   <= 1'b1;
					state_r   <= CPS_H_WAKE_CAP;
				end
				CPS_H_WAKE_CAP: state_r <= CPS_H_HIZ_CAP;
				CPS_H_HIZ_CAP: begin
					wake_hiz_r <= link.rdata[`CPS_HIZ_BIT];
					state_r    <= CPS_H_IDLE;
					// [RULE_17] write the byte back with the bit low
					if (clr_pend_r) begin
						link.addr  <= `CPS_OFS_SRC_CTL;
						link.wdata <= link.rdata & ~(8'h01 << `CPS_HIZ_BIT);
						link.wr    <= 1'b1;
						wake_hiz_r <= 1'b0;
						clr_pend_r <= 1'b0;
					end
				end
				CPS_H_SHIP2: begin
					// [RULE_06] disable follows watchdog write back to back
					link.addr  <= `CPS_OFS_MISC;
					link.wdata <= 8'h00 | (8'h01 << `CPS_BSWDIS_BIT);
					link.wr    <= 1'b1;
					nobat_r    <= 1'b1;
					state_r    <= CPS_H_IDLE;
				end
				CPS_H_IDLE: begin
					if (wr_cmd && wdata_i[`CPS_HCMD_SHIP]) begin
						link.addr  <= `CPS_OFS_WDOG;
						link.wdata <= 8'h00;
						link.wr    <= 1'b1;
						state_r    <= CPS_H_SHIP2;
					end else if (wr_cmd && wdata_i[`CPS_HCMD_CLRHIZ]) begin
						// [RULE_17] clear by reading the byte, then writing it back with the bit low
						link.addr  <= `CPS_OFS_SRC_CTL;
						link.rd    <= 1'b1;
						state_r    <= CPS_H_WAKE_CAP;
						link.wdata <= 8'h00;
						clr_pend_r <= 1'b1;
					end else if (wr_cmd && wdata_i[`CPS_HCMD_NOBAT]) begin
						// [RULE_05] no battery: disable switch
						link.addr  <= `CPS_OFS_MISC;
						link.wdata <= 8'h00 | (8'h01 << `CPS_BSWDIS_BIT);
						link.wr    <= 1'b1;
						nobat_r    <= 1'b1;
					end else if (wr_cmd && wdata_i[`CPS_HCMD_FDET]) begin
						link.addr  <= `CPS_OFS_MISC;
						link.wdata <= misc_wd | (8'h01 << `CPS_FDET_BIT);
						link.wr    <= 1'b1;
					end
				end
			endcase
		end
	end

	// Boost pin, interrupt flag and user reads
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.boost_req <= 1'b0;
			int_seen_r     <= 1'b0;
			rdata_o        <= 8'h00;
		end else if (ce_i) begin
			if (wr_ctrl)
				link.boost_req <= wdata_i[0];
			if (link.int_evt)
				int_seen_r <= 1'b1;
			else if (rd_i && addr_i == `CPS_HOFS_STATUS)
				int_seen_r <= 1'b0;
			rdata_o <= 8'h00;
			if (rd_i) begin
				unique case (addr_i)
					`CPS_HOFS_CTRL:   rdata_o <= {7'h00, link.boost_req};
					`CPS_HOFS_STATUS: rdata_o <= {4'h0, int_seen_r, busy, ~link.pg_n,
						wake_hiz_r};
					default:          rdata_o <= 8'h00;
				endcase
			end
		end
	end
endmodule // cps_host

/* cps_link_properties.sv */
// Purpose: concurrent checks on the host-to-charger link
// Assumes: one clock, synchronous active-high reset
// Notes:   instantiated beside the link interface by the testbench
`timescale 1ns/1ns
module cps_link_properties (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	// Link signals
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic [7:0] rdata,
	input  wire logic       pg_n,
	input  wire logic       int_evt,
	input  wire logic       port_type,
	input  wire logic       boost_req
);
	// All checks share the one clock and its reset
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// Read data only in the cycle after a read
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	// Never both strobes together
	strobe_excl_a: assert property (!(wr && rd))
		else $error("write and read strobe together");
	// Wake read of the control byte comes first
	wake_read_a: assert property ($fell(srst_i) |-> ##[0:2] (rd && addr == 4'h0))
		else $error("no wake read after reset");
	// Shipping writes watchdog off then switch disable
	ship_wdog_a: assert property (wr && addr == 4'h5 |-> wdata[5:4] == 2'h0)
		else $error("watchdog not cleared for shipping");
	ship_pair_a: assert property (wr && addr == 4'h5 |=> wr && addr == 4'h7 && wdata[5])
		else $error("switch disable did not follow watchdog write");
	// Interrupt is one pulse tied to power good
	int_pulse_a: assert property (int_evt |=> !int_evt)
		else $error("interrupt longer than one cycle");
	int_pg_a: assert property (int_evt |-> ##[0:1] !pg_n)
		else $error("interrupt without power good");
	pg_int_a: assert property ($fell(pg_n) |-> int_evt || $past(int_evt))
		else $error("power good without interrupt");
	pg_loss_a: assert property ($rose(pg_n) |-> !int_evt)
		else $error("interrupt on power good loss");

	// Main scenarios
	cover property (wr && addr == 4'h5);
	cover property (int_evt && !port_type);
	cover property ($rose(boost_req));
endmodule // cps_link_properties

/* testbench.sv */
// Purpose: self-checking bench of charger sequencer and host controller
// Assumes: 10 MHz clock, short delay parameters
// Notes:   detection cases are table rows; the rest are hand-written
`timescale 1ns/1ns
`include "cps_regs.svh"
module testbench;
	import cps_pkg::*;
	localparam int BIAS = 20;
	localparam int RETRY = 30;
	typedef struct packed {logic pt; logic bst; logic bg; logic [2:0] lim; logic hz;} cps_row_t;
	// Port type, boost, good battery, limit, high impedance
	cps_row_t   rows [4] = '{7'h0E, 7'h64, 7'h40, 7'h51};
	logic       clk_i, srst_i, ce, ptype;
	logic       vbus, vbat, depl, ovl, sleep, ovp_ok, load_ok, bgood, sys22, bmode, hmode, chg;
	logic [2:0] current_limit_pin_pin, current_limit_pin;
	logic       bsw, bias, tload, conv, high_impedance_state;
	logic [1:0] h_addr;
	logic [7:0] h_wdata, h_rdata, st;
	logic       h_wr, h_rd;
	int         err_total, compares, n;
	wire  [3:0] pwr = {bsw, bias, tload, conv};

	cps_link_if link ();
	assign link.port_type = ptype;

	cps_device #(.BIAS_DLY_CYC(BIAS), .RETRY_CYC(RETRY), .SETTLE_CYC(4)) u_cps_device (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .link(link),
		.vbus_uvlo_ok_i(vbus), .vbat_uvlo_ok_i(vbat), .bat_above_depl_i(depl),
		.sys_overload_i(ovl), .vbus_above_sleep_i(sleep), .vbus_below_ovp_i(ovp_ok),
		.vbus_loaded_ok_i(load_ok), .bat_good_i(bgood), .sys_above_2v2_i(sys22),
		.boost_mode_i(bmode), .host_mode_i(hmode), .charge_en_i(chg), .current_limit_pin_pin_i(current_limit_pin_pin),
		.bsw_on_o(bsw), .bias_en_o(bias), .test_load_o(tload), .conv_en_o(conv),
		.hiz_o(high_impedance_state), .current_limit_pin_active_o(current_limit_pin));
	cps_host u_cps_host (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .addr_i(h_addr),
		.wdata_i(h_wdata), .wr_i(h_wr), .rd_i(h_rd), .rdata_o(h_rdata), .link(link));
	cps_link_properties u_cps_link_properties (.clk_i(clk_i), .srst_i(srst_i),
		.addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
		.pg_n(link.pg_n), .int_evt(link.int_evt), .port_type(link.port_type),
		.boost_req(link.boost_req));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic give_up();
		err_total++;
		$display("ERROR %0t: wait ran out", $time);
		close_out();
	endtask

	// Level picked for bounded waits
	function automatic logic pick(input int sel);
		case (sel)
			0: return bias;
			1: return tload;
			default: return link.pg_n;
		endcase
	endfunction

	task automatic wait_for(input int sel, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (pick(sel) !== v && cnt < lim) begin
			@(posedge clk_i);
			#1;
			cnt++;
		end
		if (pick(sel) !== v) give_up();
	endtask

	task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		h_addr <= a;
		h_wdata <= d;
		h_wr <= 1'b1;
		@(posedge clk_i);
		h_wr <= 1'b0;
	endtask

	task automatic host_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_i);
		h_addr <= a;
		h_rd <= 1'b1;
		@(posedge clk_i);
		h_rd <= 1'b0;
		@(negedge clk_i);
		d = h_rdata;
	endtask

	// Command once the controller is no longer busy
	task automatic host_cmd(input logic [7:0] d);
		logic [7:0] s;
		int k;
		s = 8'hFF;
		k = 0;
		while (s[2] !== 1'b0 && k < 50) begin
			host_rd(`CPS_HOFS_STATUS, s);
			k++;
		end
		if (s[2] !== 1'b0) give_up();
		host_wr(`CPS_HOFS_CMD, d);
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		give_up();
	end

	// Main sequence
	initial begin
		{srst_i, ce, ptype, current_limit_pin_pin, ovp_ok, sys22, chg} = 9'h1FF;
		{vbus, vbat, depl, ovl, sleep, load_ok, bgood, bmode, hmode} = 9'h000;
		{h_addr, h_wdata, h_wr, h_rd, err_total, compares} = '0;
		ptype = 1'b0;
		repeat (6) @(posedge clk_i);
		chk({3'h0, pwr, high_impedance_state}, 8'h01);
		chk({7'h00, link.pg_n}, 8'h01);
		srst_i <= 1'b0;
		vbat <= 1'b1;
		depl <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk({4'h0, pwr}, 8'h08);
		ovl <= 1'b1;
		repeat (5) @(posedge clk_i);
		ovl <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk({7'h00, bsw}, 8'h00);
		vbus <= 1'b1;
		sleep <= 1'b1;
		wait_for(0, 1'b1, 100, n);
		chk({7'h00, n >= BIAS && n <= BIAS + 8}, 8'h01);
		chk({7'h00, bsw}, 8'h01);
		wait_for(1, 1'b1, 20, n);
		wait_for(1, 1'b0, 20, n);
		wait_for(1, 1'b1, RETRY + 20, n);
		chk({7'h00, n >= RETRY && n <= RETRY + 8}, 8'h01);
		chk({7'h00, link.pg_n}, 8'h01);
		@(posedge clk_i);
		load_ok <= 1'b1;
		wait_for(2, 1'b0, 80, n);
		repeat (4) @(posedge clk_i);
		chk({4'h0, pwr}, 8'h0D);
		chk({5'h00, current_limit_pin}, 8'h07);
		host_rd(`CPS_HOFS_STATUS, st);
		chk(st & 8'h0A, 8'h0A);
		chg <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk({7'h00, bsw}, 8'h00);
		chg <= 1'b1;
		current_limit_pin_pin <= 3'h2;
		repeat (4) @(posedge clk_i);
		chk({5'h00, current_limit_pin}, 8'h02);
		sys22 <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk({5'h00, current_limit_pin}, 8'h00);
		sys22 <= 1'b1;
		current_limit_pin_pin <= 3'h7;
		hmode <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk_i);
			ptype <= rows[i].pt;
			bgood <= rows[i].bg;
			host_wr(`CPS_HOFS_CTRL, {7'h00, rows[i].bst});
			repeat (4) @(posedge clk_i);
			host_cmd(8'h04);
			repeat (8) @(posedge clk_i);
			chk({5'h00, current_limit_pin}, {5'h00, rows[i].lim});
			chk({7'h00, high_impedance_state}, {7'h00, rows[i].hz});
		end
		chk({7'h00, bias}, 8'h00);
		vbus <= 1'b0;
		ptype <= 1'b0;
		repeat (6) @(posedge clk_i);
		vbus <= 1'b1;
		repeat (BIAS + 20) @(posedge clk_i);
		chk({6'h00, high_impedance_state, link.pg_n}, 8'h03);
		host_cmd(8'h02);
		repeat (8) @(posedge clk_i);
		chk({7'h00, high_impedance_state}, 8'h00);
		host_cmd(8'h01);
		repeat (5) @(posedge clk_i);
		chk({7'h00, bsw}, 8'h00);
		hmode <= 1'b0;
		vbus <= 1'b0;
		repeat (6) @(posedge clk_i);
		vbus <= 1'b1;
		wait_for(2, 1'b0, 150, n);
		repeat (6) @(posedge clk_i);
		chk({5'h00, current_limit_pin}, 8'h07);
		chk({7'h00, bsw}, 8'h01);
		ce <= 1'b0;
		chg <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk({7'h00, bsw}, 8'h01);
		ce <= 1'b1;
		chg <= 1'b1;
		repeat (4) @(posedge clk_i);
		host_cmd(8'h08);
		repeat (5) @(posedge clk_i);
		chk({7'h00, bsw}, 8'h00);
		bmode <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({7'h00, bias}, 8'h00);
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({4'h0, pwr}, 8'h00);
		srst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		close_out();
	end
endmodule // testbench
